// ### drive_select_pkg.sv
// Constants shared by the drive select, status gating and fault latch logic.
// Overview of operation
// - Status pins are driven only while the drive is selected.
// - Jumpers pick one of four unit-select lines; the others are ignored.
// - Radial option makes the drive permanently selected.
// - Write error is latched and held until its clearing event.
// - Default: write-enable drop and reassert clears the latch.
// - Option: select drop and reassert clears the latch instead.
// - Burn-in jumper makes the drive seek between cylinder zero and top.
// - During burn-in every host control input is ignored.
// - Shared control inputs act only while the drive is selected, by own select line or radial option.
// - Control inputs are active low; undriven lines float high.
// - Head index lines decode as binary, line zero least significant.
// - Selected acknowledge goes low only when configured and selected, by own select line or radial option.
// - While the drive is active, write enable without current, or current without it, is a fault.
package drive_select_pkg;
  localparam int CLK_MHZ = 40;
  localparam int BURN_STEP_US = 10;
  localparam int BURN_STEP_CYC = BURN_STEP_US * CLK_MHZ;
  localparam logic [8:0] BURN_TICK_LAST = 9'(BURN_STEP_CYC - 1);
  localparam logic [8:0] CYL_LAST = 9'h131;

  // Positions inside the synchronised input vector.
  localparam int IN_WG = 0;
  localparam int IN_STEP = 1;
  localparam int IN_DIR = 2;
  localparam int IN_HEAD_LSB = 3;
  localparam int IN_SEL_LSB = 7;
  localparam int IN_JMP_LSB = 11;
  localparam int IN_W = 19;
  // Active-low cable lines idle high, jumper bits idle at not fitted.
  localparam logic [18:0] SYNC_RST = 19'h007FF;

  // Jumper pair positions, one bit per shorted pair.
  localparam int JMP_SEL_LSB = 0;
  localparam int JMP_BURNIN = 4;
  localparam int JMP_ALT_CLEAR = 5;
  localparam int JMP_RADIAL = 7;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_STATE = 4'h0;
  localparam logic [3:0] ADDR_EVENT = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;

  // Event bits, shared by the event and mask registers.
  localparam int EV_W = 4;
  localparam int EV_WF_SET = 0;
  localparam int EV_WF_CLR = 1;
  localparam int EV_SELECT = 2;
  localparam int EV_STEP = 3;
  localparam logic [3:0] MASK_RST = 4'h0;

  // Fields of the state register.
  localparam int ST_SELECTED = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_WF = 2;
  localparam int ST_CONFIG_OK = 3;
  localparam int ST_BURNIN = 4;
  localparam int ST_HEAD_LSB = 8;
  localparam int ST_CYL_LSB = 16;
endpackage

// ### drive_select_status_gating.sv
// Drive select decoding, status pin gating, write fault latch and burn-in.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module drive_select_status_gating (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_gate_n,
  input wire logic [3:0] head_sel_n,
  input wire logic step_n,
  input wire logic dir_in_n,
  input wire logic [3:0] unit_sel_n,
  input wire logic [7:0] option_jumper_block,
  input wire logic write_current,
  input wire logic seek_done,
  input wire logic track_zero,
  input wire logic rev_marker,
  input wire logic drive_ready,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  output logic seek_done_n_out,
  output logic seek_done_n_oe,
  output logic write_error_n_out,
  output logic write_error_n_oe,
  output logic rev_marker_n_out,
  output logic rev_marker_n_oe,
  output logic ready_n_out,
  output logic ready_n_oe,
  output logic track_zero_n_out,
  output logic track_zero_n_oe,
  output logic unit_selected_n_out,
  output logic unit_selected_n_oe,
  output logic [3:0] head_index,
  output logic step_pulse,
  output logic step_inward,
  output logic write_enable,
  output logic write_inhibit,
  output logic burn_in_active
);

  function automatic logic one_hot4(input logic [3:0] v);
    one_hot4 = (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
  endfunction

  function automatic logic addressed(input logic [3:0] act,
                                     input logic [3:0] choice);
    addressed = one_hot4(choice) && ((act & choice) != 4'h0);
  endfunction

  wire [drive_select_pkg::IN_W-1:0] raw_in;
  logic [drive_select_pkg::IN_W-1:0] sync_meta;
  logic [drive_select_pkg::IN_W-1:0] sync_q;

  assign raw_in = {option_jumper_block, unit_sel_n, head_sel_n,
                   dir_in_n, step_n, wr_gate_n};

  // Two flops per line; only the second stage feeds any logic.
  genvar gi;
  generate
    for (gi = 0; gi < drive_select_pkg::IN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_meta[gi] <= drive_select_pkg::SYNC_RST[gi];
          sync_q[gi] <= drive_select_pkg::SYNC_RST[gi];
        end else begin
          sync_meta[gi] <= raw_in[gi];
          sync_q[gi] <= sync_meta[gi];
        end
      end
    end
  endgenerate

  // Low on the cable means asserted.
  wire wg_act = ~sync_q[drive_select_pkg::IN_WG];
  wire step_act = ~sync_q[drive_select_pkg::IN_STEP];
  wire dir_act = ~sync_q[drive_select_pkg::IN_DIR];
  wire [3:0] head_act =
    ~sync_q[drive_select_pkg::IN_HEAD_LSB +: 4];
  wire [3:0] sel_act = ~sync_q[drive_select_pkg::IN_SEL_LSB +: 4];
  wire [7:0] jumpers = sync_q[drive_select_pkg::IN_JMP_LSB +: 8];

  wire [3:0] sel_choice = jumpers[drive_select_pkg::JMP_SEL_LSB +: 4];
  wire radial = jumpers[drive_select_pkg::JMP_RADIAL];
  wire burnin = jumpers[drive_select_pkg::JMP_BURNIN];
  wire alt_clear = jumpers[drive_select_pkg::JMP_ALT_CLEAR];

  wire config_ok = radial | one_hot4(sel_choice);
  wire own_sel = addressed(sel_act, sel_choice);
  wire selected = radial | own_sel;
  // Burn-in shuts out the whole host interface, select lines included.
  wire active = selected & ~burnin;

  logic step_prev;
  logic clr_src_prev;
  logic clr_dropped;
  logic wf_latch;
  logic sel_prev;

  wire step_edge = step_act & ~step_prev;
  wire host_step = active & step_edge;
  wire host_wg = active & wg_act;

  // Mismatch between write enable and write current while active.
  wire fault_cond = active & (host_wg ^ write_current);

  // The clearing source is the write enable or the own select line.
  wire clr_src = alt_clear ? (own_sel & ~burnin) : host_wg;
  wire clr_fall = clr_src_prev & ~clr_src;
  wire clr_rise = clr_src & ~clr_src_prev;
  wire next_dropped = wf_latch & ~fault_cond &
                      (clr_fall | (clr_dropped & ~clr_rise));
  wire clr_evt = wf_latch & clr_dropped & clr_rise & ~fault_cond;
  // A new fault in the clearing cycle keeps the latch set.
  wire next_wf = fault_cond | (wf_latch & ~clr_evt);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev <= 1'b0;
      clr_src_prev <= 1'b0;
      clr_dropped <= 1'b0;
      wf_latch <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      step_prev <= step_act;
      clr_src_prev <= clr_src;
      clr_dropped <= next_dropped;
      wf_latch <= next_wf;
      sel_prev <= active;
    end
  end

  // Burn-in stepping: a divider tick moves one cylinder, turning at ends.
  logic [8:0] burn_tick_cnt;
  logic [8:0] burn_cyl;
  logic burn_dir_in;
  wire burn_tick =
    burnin && (burn_tick_cnt == drive_select_pkg::BURN_TICK_LAST);
  wire burn_at_top = (burn_cyl == drive_select_pkg::CYL_LAST);
  wire burn_at_zero = (burn_cyl == 9'h000);
  wire next_burn_dir = burn_at_top ? 1'b0 :
                       (burn_at_zero ? 1'b1 : burn_dir_in);
  wire [8:0] next_burn_cyl = next_burn_dir ? burn_cyl + 9'h001
                                           : burn_cyl - 9'h001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burn_tick_cnt <= 9'h000;
      burn_cyl <= 9'h000;
      burn_dir_in <= 1'b1;
    end else if (!burnin) begin
      burn_tick_cnt <= 9'h000;
      burn_cyl <= 9'h000;
      burn_dir_in <= 1'b1;
    end else if (burn_tick) begin
      burn_tick_cnt <= 9'h000;
      burn_cyl <= next_burn_cyl;
      burn_dir_in <= next_burn_dir;
    end else begin
      burn_tick_cnt <= burn_tick_cnt + 9'h001;
    end
  end

  // Drive-side controls, all registered.
  wire next_step = burnin ? burn_tick : host_step;
  wire next_inward = burnin ? next_burn_dir : (active & dir_act);
  wire next_inhibit = next_wf;
  wire next_wenable = host_wg & ~next_wf;
  wire [3:0] next_head = active ? head_act : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_pulse <= 1'b0;
      step_inward <= 1'b0;
      write_enable <= 1'b0;
      write_inhibit <= 1'b0;
      head_index <= 4'h0;
      burn_in_active <= 1'b0;
    end else begin
      step_pulse <= next_step;
      step_inward <= next_inward;
      write_enable <= next_wenable;
      write_inhibit <= next_inhibit;
      head_index <= next_head;
      burn_in_active <= burnin;
    end
  end

  // Open-collector status pins: level always low, enable means asserted.
  logic pin_level;
  wire ack_next = active & config_ok & (radial | own_sel);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 1'b0;
      seek_done_n_oe <= 1'b0;
      write_error_n_oe <= 1'b0;
      rev_marker_n_oe <= 1'b0;
      ready_n_oe <= 1'b0;
      track_zero_n_oe <= 1'b0;
      unit_selected_n_oe <= 1'b0;
    end else begin
      pin_level <= 1'b0;
      seek_done_n_oe <= active & seek_done;
      write_error_n_oe <= active & next_wf;
      rev_marker_n_oe <= active & rev_marker;
      ready_n_oe <= active & drive_ready;
      track_zero_n_oe <= active & track_zero;
      unit_selected_n_oe <= ack_next;
    end
  end

  assign seek_done_n_out = pin_level;
  assign write_error_n_out = pin_level;
  assign rev_marker_n_out = pin_level;
  assign ready_n_out = pin_level;
  assign track_zero_n_out = pin_level;
  assign unit_selected_n_out = pin_level;

  // Sticky events, mask and interrupt.
  logic [drive_select_pkg::EV_W-1:0] ev_status;
  logic [drive_select_pkg::EV_W-1:0] ev_mask;
  wire [drive_select_pkg::EV_W-1:0] ev_raw;

  assign ev_raw[drive_select_pkg::EV_WF_SET] = next_wf & ~wf_latch;
  assign ev_raw[drive_select_pkg::EV_WF_CLR] = clr_evt;
  assign ev_raw[drive_select_pkg::EV_SELECT] = active & ~sel_prev;
  assign ev_raw[drive_select_pkg::EV_STEP] = next_step;

  wire rd_state = rd_en && (addr == drive_select_pkg::ADDR_STATE);
  wire rd_event = rd_en && (addr == drive_select_pkg::ADDR_EVENT);
  wire rd_mask = rd_en && (addr == drive_select_pkg::ADDR_MASK);
  wire wr_mask = wr_en && (addr == drive_select_pkg::ADDR_MASK);

  // A read clears the events; an event in the same cycle survives.
  wire [drive_select_pkg::EV_W-1:0] next_status =
    (rd_event ? {drive_select_pkg::EV_W{1'b0}} : ev_status) | ev_raw;
  wire [drive_select_pkg::EV_W-1:0] next_mask =
    wr_mask ? wdata[drive_select_pkg::EV_W-1:0] : ev_mask;
  wire next_irq = |(next_status & next_mask);

  wire [31:0] state_word =
    (32'(selected) << drive_select_pkg::ST_SELECTED) |
    (32'(active) << drive_select_pkg::ST_ACTIVE) |
    (32'(wf_latch) << drive_select_pkg::ST_WF) |
    (32'(config_ok) << drive_select_pkg::ST_CONFIG_OK) |
    (32'(burnin) << drive_select_pkg::ST_BURNIN) |
    (32'(head_act) << drive_select_pkg::ST_HEAD_LSB) |
    (32'(burn_cyl) << drive_select_pkg::ST_CYL_LSB);
  wire [31:0] next_rdata =
    rd_state ? state_word :
    rd_event ? 32'(ev_status) :
    rd_mask ? 32'(ev_mask) : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_status <= {drive_select_pkg::EV_W{1'b0}};
      ev_mask <= drive_select_pkg::MASK_RST;
      irq <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ev_status <= next_status;
      ev_mask <= next_mask;
      irq <= next_irq;
      rdata <= next_rdata;
    end
  end

endmodule

// ### drive_select_status_gating_props.sv
// Checker of select decoding, status gating and write fault latch timing.
`timescale 1ns/10ps
module drive_select_status_gating_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_gate_n,
  input wire logic [3:0] head_sel_n,
  input wire logic [3:0] unit_sel_n,
  input wire logic [7:0] option_jumper_block,
  input wire logic [3:0] head_index,
  input wire logic write_enable,
  input wire logic write_inhibit,
  input wire logic burn_in_active,
  input wire logic unit_selected_n_oe,
  input wire logic seek_done_n_oe,
  input wire logic write_error_n_oe,
  input wire logic ready_n_oe
);
  logic [1:0] up;
  wire own_lo = |(~unit_sel_n & option_jumper_block[3:0]);
  wire ok = up == 2'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // History three edges deep is only trusted once it postdates reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up <= 2'h0;
    else if (!ok) up <= up + 2'h1;
  end
  sequence s_wg_fall; $past(wr_gate_n, 4) && !$past(wr_gate_n, 3); endsequence
  sequence s_sel_fall; !$past(own_lo, 4) && $past(own_lo, 3); endsequence
  property p_gate; (seek_done_n_oe || write_error_n_oe || ready_n_oe)
    |-> unit_selected_n_oe; endproperty
  a_gate: assert property (p_gate) else $error("status while idle");
  property p_sel; ok && unit_selected_n_oe && !$past(option_jumper_block[7], 3)
    |-> $past(own_lo, 3); endproperty
  a_sel: assert property (p_sel) else $error("wrong select");
  property p_radial; ok && $past(option_jumper_block, 3) == 8'h80
    |-> unit_selected_n_oe; endproperty
  a_radial: assert property (p_radial) else $error("radial idle");
  property p_burn; burn_in_active |-> !unit_selected_n_oe && !write_enable;
  endproperty
  a_burn: assert property (p_burn) else $error("host obeyed");
  property p_wen; write_enable |-> !write_inhibit; endproperty
  a_wen: assert property (p_wen) else $error("write during fault");
  property p_head; ok && unit_selected_n_oe
    |-> head_index == ~$past(head_sel_n, 3); endproperty
  a_head: assert property (p_head) else $error("head decode");
  property p_clr_wg; ok && $fell(write_inhibit)
    && !$past(option_jumper_block[5], 3) |-> s_wg_fall; endproperty
  a_clr_wg: assert property (p_clr_wg) else $error("bad clear");
  property p_clr_sel; ok && $fell(write_inhibit)
    && $past(option_jumper_block[5], 3) |-> s_sel_fall; endproperty
  a_clr_sel: assert property (p_clr_sel) else $error("bad alt clear");
endmodule
bind drive_select_status_gating drive_select_status_gating_props props (
  .clk, .rst_n, .wr_gate_n, .head_sel_n, .unit_sel_n, .option_jumper_block,
  .head_index, .write_enable, .write_inhibit, .burn_in_active,
  .unit_selected_n_oe, .seek_done_n_oe, .write_error_n_oe, .ready_n_oe);

// ### drive_select_status_gating_tb.sv
// Self-checking bench for drive select, status gating and fault latch.
`timescale 1ns/10ps
module drive_select_status_gating_tb;
  logic clk = 1'h0, rst_n = 1'h0, sel_on = 1'h0, wg_on = 1'h0, inward = 1'h0;
  logic step_on = 1'h0, write_current = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
  logic irq, ack, sd_oe, we_oe, rdy_oe, inh, burn, step_pulse;
  logic tz_oe, rv_oe, inw, wen;
  logic wr_gate_n, step_n, dir_in_n;
  logic [1:0] line = 2'h0;
  logic [3:0] head = 4'h0, stat = 4'h0, addr = 4'h0, head_index;
  logic [3:0] head_sel_n, unit_sel_n;
  logic [7:0] jmp = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d, rng = 32'h4ACC24BD;
  int failures = 0, checks = 0;
  always #12.5 clk = ~clk;
  host_ctrl_model host (.clk, .line, .sel_on, .wg_on, .step_on, .inward,
    .head, .unit_sel_n, .wr_gate_n, .step_n, .dir_in_n, .head_sel_n);
  drive_select_status_gating uut (.clk, .rst_n, .wr_gate_n, .head_sel_n,
    .step_n, .dir_in_n, .unit_sel_n, .option_jumper_block(jmp),
    .write_current, .seek_done(stat[0]), .track_zero(stat[1]),
    .rev_marker(stat[2]), .drive_ready(stat[3]), .addr, .wdata, .wr_en,
    .rd_en, .rdata, .irq, .seek_done_n_out(), .seek_done_n_oe(sd_oe),
    .write_error_n_out(), .write_error_n_oe(we_oe), .rev_marker_n_out(),
    .rev_marker_n_oe(rv_oe), .ready_n_out(), .ready_n_oe(rdy_oe),
    .track_zero_n_out(), .track_zero_n_oe(tz_oe), .unit_selected_n_out(),
    .unit_selected_n_oe(ack), .head_index, .step_pulse, .step_inward(inw),
    .write_enable(wen), .write_inhibit(inh), .burn_in_active(burn));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] gated(input logic on, input logic [31:0] v);
    return on ? v : 32'h0;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic wg(input logic on, input logic cur);
    wg_on <= on;
    // Current follows the gate once the gate has crossed the synchroniser.
    cyc(2);
    write_current <= cur;
    cyc(6);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    chk(32'({ack, sd_oe, we_oe, inh, irq}), 32'h0);
    rst_n <= 1'h1;
    cyc(2);
    rd(drive_select_pkg::ADDR_MASK);
    chk(d, 32'(drive_select_pkg::MASK_RST));
    rd(4'hC);
    chk(d, 32'h0);
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 4; k++) begin
        rng = xs(rng);
        jmp <= 8'(1 << j);
        line <= 2'(k);
        sel_on <= 1'h1;
        head <= rng[3:0];
        stat <= rng[7:4];
        inward <= rng[8];
        cyc(7);
        chk(32'(ack), 32'(j == k));
        chk(32'(head_index), gated(j == k, 32'(head)));
        chk(32'({sd_oe, tz_oe, rv_oe, rdy_oe}),
            gated(j == k, 32'({stat[0], stat[1], stat[2], stat[3]})));
        chk(32'(inw), 32'(j == k && inward));
      end
    end
    for (int r = 0; r < 2; r++) begin
      jmp <= r ? 8'h80 : 8'h02;
      line <= 2'h0;
      sel_on <= r ? 1'h0 : 1'h1;
      cyc(6);
      rd(drive_select_pkg::ADDR_EVENT);
      step_on <= 1'h1;
      cyc(3);
      step_on <= 1'h0;
      wg(1'h1, 1'h0);
      rd(drive_select_pkg::ADDR_EVENT);
      chk(32'({ack, d[drive_select_pkg::EV_STEP], inh}),
          32'({3{r[0]}}));
      wg(1'h0, 1'h0);
    end
    // A reset in mid-run must drop the fault latched in radial mode.
    rst_n <= 1'h0;
    cyc(2);
    chk(32'({ack, we_oe, inh}), 32'h0);
    rst_n <= 1'h1;
    jmp <= 8'h01;
    sel_on <= 1'h1;
    cyc(6);
    rd(drive_select_pkg::ADDR_EVENT);
    wg(1'h1, 1'h0);
    chk(32'({we_oe, inh, irq}), 32'h6);
    addr <= drive_select_pkg::ADDR_MASK;
    wdata <= 32'hF;
    wr_en <= 1'h1;
    cyc(1);
    wr_en <= 1'h0;
    cyc(2);
    chk(32'(irq), 32'h1);
    rd(drive_select_pkg::ADDR_EVENT);
    chk(32'(d[drive_select_pkg::EV_WF_SET]), 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0);
    write_current <= 1'h1;
    cyc(6);
    chk(32'(inh), 32'h1);
    wg(1'h0, 1'h0);
    chk(32'(inh), 32'h1);
    wg(1'h1, 1'h1);
    chk(32'(inh), 32'h0);
    chk(32'(wen), 32'h1);
    wg(1'h0, 1'h0);
    jmp <= 8'h21;
    cyc(6);
    wg(1'h1, 1'h0);
    wg(1'h0, 1'h0);
    wg(1'h1, 1'h1);
    wg(1'h0, 1'h0);
    chk(32'(inh), 32'h1);
    sel_on <= 1'h0;
    cyc(6);
    sel_on <= 1'h1;
    cyc(6);
    chk(32'(inh), 32'h0);
    jmp <= 8'h11;
    wg(1'h1, 1'h0);
    chk(32'({burn, ack, inh}), 32'h4);
    for (int i = 0; i < 900 && step_pulse !== 1'h1; i++) @(posedge clk);
    chk(32'(step_pulse), 32'h1);
    end_of_test;
  end
endmodule

// ### host_ctrl_model.sv
// Host controller model driving the select and shared control lines.
`timescale 1ns/10ps
module host_ctrl_model (
  input wire logic clk,
  input wire logic [1:0] line,
  input wire logic sel_on,
  input wire logic wg_on,
  input wire logic step_on,
  input wire logic inward,
  input wire logic [3:0] head,
  output logic [3:0] unit_sel_n,
  output logic wr_gate_n,
  output logic step_n,
  output logic dir_in_n,
  output logic [3:0] head_sel_n
);
  logic [3:0] head_q;
  always_ff @(posedge clk) if (!wg_on) head_q <= head;
  // One line low at most; released lines float high on the pull-up.
  assign unit_sel_n = sel_on ? ~(4'h1 << line) : 4'hF;
  assign wr_gate_n = ~wg_on;
  assign step_n = ~step_on;
  assign dir_in_n = ~inward;
  assign head_sel_n = ~head_q;
endmodule
